/* File: dv/gmf_host_model.sv */
`timescale 1ns/1ps
// ==================================================
// Host on the serial bus; pull-ups hold both lines high when idle
module gmf_host_model (
  output logic scl, // Serial clock, still between frames
  output logic sda // Serial data
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start, address byte, released ack slot, stop; 400 ns bit
  task automatic wake(input logic [6:0] a);
    logic [7:0] b;
    b = {a, 1'b0};
    sda = 1'b0;
    #200;
    for (int i = 7; i >= -1; i--) begin
      scl = 1'b0;
      #100;
      sda = (i >= 0) ? b[i] : 1'b1;
      #100;
      scl = 1'b1;
      #200;
    end
    scl = 1'b0;
    #100;
    sda = 1'b0;
    #100;
    scl = 1'b1;
    #100;
    sda = 1'b1;
    #200;
  endtask
endmodule

/* File: dv/gmf_mode_ctrl_asserts.sv */
`timescale 1ns/1ps
module gmf_mode_ctrl_asserts (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic rd, // Read strobe
  input wire logic measValid, // New sample
  input wire gmf_pkg::gmf_mode_e mode, // Mode
  input wire logic gaugeRun, // Gauging active
  input wire logic hfOscOn, // Fast oscillator
  input wire logic dataUpdate, // Publish pulse
  input wire logic [15:0] rdata, // Read data
  input wire logic [15:0] status // Flags
);
  import gmf_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==================================================
  // Mode sequencing
  property p_por_exit;
    $past(mode) == GMF_POR && mode != GMF_POR |-> mode == GMF_INIT;
  endproperty
  a_por_exit: assert property (p_por_exit) else $error("power-on left to wrong mode");
  property p_init_idle;
    (mode == GMF_INIT) [*2] |-> !gaugeRun;
  endproperty
  a_init_idle: assert property (p_init_idle) else $error("gauging while initializing");
  property p_cfg_idle;
    (mode == GMF_CFGUPD) [*2] |-> !gaugeRun;
  endproperty
  a_cfg_idle: assert property (p_cfg_idle) else $error("gauging in config update");
  property p_cfg_flag;
    $rose(status[ST_CFGUPD]) |-> mode == GMF_CFGUPD;
  endproperty
  a_cfg_flag: assert property (p_cfg_flag) else $error("update flag outside update");
  property p_publish;
    measValid && mode == GMF_NORMAL |=> dataUpdate;
  endproperty
  a_publish: assert property (p_publish) else $error("sample not published");
  // Sleep only after calibration, with the fast clock stopped
  property p_sleep_entry;
    mode == GMF_SLEEP && $past(mode) != GMF_SLEEP |-> $past(mode) == GMF_CAL;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without calibration");
  property p_sleep_osc;
    (mode == GMF_SLEEP) [*2] |-> !hfOscOn;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator on in sleep");
  property p_hib_entry;
    mode == GMF_HIB && $past(mode) != GMF_HIB
      |-> $past(mode) == GMF_NORMAL || $past(mode) == GMF_SLEEP;
  endproperty
  a_hib_entry: assert property (p_hib_entry) else $error("hibernate from wrong mode");
  property p_hib_wake;
    $past(mode) == GMF_HIB && mode != GMF_HIB |-> mode == GMF_INIT || mode == GMF_POR;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate left wrongly");
  property p_rd_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule
bind gmf_mode_ctrl gmf_mode_ctrl_asserts u_chk (.clk(clk), .rst_b(rst_b), .rd(rd),
  .measValid(measValid), .mode(mode), .gaugeRun(gaugeRun), .hfOscOn(hfOscOn),
  .dataUpdate(dataUpdate), .rdata(rdata), .status(status));

/* File: dv/tb_gmf_mode_ctrl.sv */
`timescale 1ns/1ps
module tb_gmf_mode_ctrl;
  import gmf_pkg::*;
  typedef struct packed {
    logic signed [15:0] t;
    logic inh;
  } gmf_row_s;
  gmf_row_s rows [7] = '{'{16'sh00fa, 1'b0}, '{16'sh01cc, 1'b1}, '{16'sh01a4, 1'b1},
    '{16'sh0190, 1'b0}, '{16'shfff6, 1'b1}, '{16'sh001e, 1'b1}, '{16'sh0032, 1'b0}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b1;
  logic mv = 1'b0;
  logic ocvDone = 1'b0;
  logic calDone = 1'b0;
  logic learn = 1'b0;
  logic signed [15:0] sTemp = 16'sh012c;
  logic signed [15:0] cur = 16'sh0000;
  logic signed [15:0] volt = 16'sh0f00;
  logic [15:0] capStep = 16'h0005;
  logic [15:0] rdata, status, v;
  logic signed [15:0] effTemp;
  logic gaugeRun, hfOscOn, ocvStart, calStart, dataUpdate, cpuHalted, dLoad, rmf, scl, sda;
  gmf_mode_e mode;
  int n_errors = 0;
  int checks_done = 0;
  int ocvN = 0;
  int calN = 0;
  int rmN = 0;
  int ldN = 0;
  int k;
  always #25 clk = ~clk;
  gmf_host_model host (.scl(scl), .sda(sda));
  gmf_mode_ctrl #(.OT_CYC(50), .TAPER_CYC(40)) dut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .battery_present_pin(pin), .sclPin(scl),
    .sdaPin(sda), .measValid(mv), .sensorTemp(sTemp), .mean_current_reading(cur),
    .cellVoltage(volt), .capStep(capStep), .ocvDone(ocvDone), .calDone(calDone),
    .capLearnPulse(learn), .resLearnPulse(learn), .mode(mode), .gaugeRun(gaugeRun),
    .hfOscOn(hfOscOn), .ocvStart(ocvStart), .calStart(calStart), .dataUpdate(dataUpdate),
    .cpuHalted(cpuHalted), .defaultsLoad(dLoad), .remaining_from_full_on_termination(rmf),
    .effTemp(effTemp), .status(status));
  always @(posedge clk) begin
    if (ocvStart === 1'b1)
      ocvN++;
    if (calStart === 1'b1)
      calN++;
    if (rmf === 1'b1)
      rmN++;
    if (dLoad === 1'b1)
      ldN++;
  end
  // ==================================================
  // Shared tasks
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // Idle cycle after each strobe keeps one assignment per step
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic meas(input int n);
    repeat (n) begin
      mv <= 1'b1;
      @(posedge clk);
      mv <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic wmode(input gmf_mode_e m);
    for (int j = 0; j < 2000 && mode !== m; j++)
      @(posedge clk);
    chk("mode", mode, m);
    if (mode !== m)
      test_done();
  endtask
  task automatic flag(input string n, input int b, input logic e);
    rdr(OFS_STATUS);
    chk(n, v[b], e);
  endtask
  task automatic ocv_done();
    ocvDone <= 1'b1;
    @(posedge clk);
    ocvDone <= 1'b0;
    @(posedge clk);
  endtask
  // ==================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("halt", cpuHalted, 1'b1);
    wmode(GMF_INIT);
    flag("defaults", ST_DEFAULTS, 1'b1);
    rdr(OFS_CTRL);
    chk("ctrl", v, CTRL_RESET);
    rdr(4'hf);
    chk("unmapped", v, 16'h0000);
    wrr(OFS_CMD, 16'h00ff);
    chk("badcmd", mode, GMF_INIT);
    learn <= 1'b1;
    @(posedge clk);
    learn <= 1'b0;
    wrr(OFS_CTRL, 16'h0010);
    rdr(OFS_STATUS);
    chk("learned", v[7:6], 2'b11);
    k = ocvN;
    wrr(OFS_CMD, CMD_INSERT);
    repeat (4) @(posedge clk);
    chk("ocv", ocvN > k, 1'b1);
    rdr(OFS_STATUS);
    chk("unlearned", v[7:6], 2'b00);
    ocv_done();
    wmode(GMF_NORMAL);
    meas(2);
    rdr(OFS_TEMP);
    chk("sensor", v, 16'h012c);
    wrr(OFS_CTRL, 16'h0011);
    rdr(OFS_TEMP);
    chk("tdef", v, TEMP_DEFAULT);
    foreach (rows[i]) begin
      wrr(OFS_TEMP, rows[i].t);
      meas(1);
      chk("efft", effTemp, rows[i].t);
      flag("inhibit", ST_CHARGE_INHIBIT_FLAG, rows[i].inh);
    end
    // Discharge over-temperature must persist 50 cycles
    wrr(OFS_TEMP, 16'sh0258);
    cur <= 16'shff9c;
    meas(5);
    flag("otd early", ST_OTD, 1'b0);
    meas(15);
    flag("otd", ST_OTD, 1'b1);
    wrr(OFS_TEMP, 16'sh0226);
    meas(1);
    flag("otd rec", ST_OTD, 1'b0);
    wrr(OFS_TEMP, TEMP_DEFAULT);
    cur <= 16'sh0064;
    meas(2);
    flag("chg", ST_CHG, 1'b1);
    wrr(OFS_TEMP, 16'sh0230);
    meas(20);
    flag("otc", ST_OTC, 1'b1);
    wrr(OFS_TEMP, 16'sh01f4);
    meas(1);
    flag("otc rec", ST_OTC, 1'b0);
    cur <= 16'sh0032;
    volt <= 16'sh1036;
    k = rmN;
    meas(30);
    flag("term", ST_CHG, 1'b0);
    chk("rmfull", rmN > k, 1'b1);
    cur <= 16'sh0005;
    k = calN;
    wrr(OFS_CTRL, 16'h0015);
    wmode(GMF_CAL);
    @(posedge clk);
    chk("cal", calN > k, 1'b1);
    calDone <= 1'b1;
    @(posedge clk);
    calDone <= 1'b0;
    wmode(GMF_SLEEP);
    chk("osc", hfOscOn, 1'b0);
    cur <= 16'sh0014;
    meas(1);
    wmode(GMF_NORMAL);
    cur <= 16'sh0003;
    wrr(OFS_CTRL, 16'h0019);
    wmode(GMF_HIB);
    flag("ocv clr", ST_OCV_TAKEN, 1'b0);
    host.wake(7'h22);
    repeat (20) @(posedge clk);
    chk("other addr", mode, GMF_HIB);
    k = ocvN;
    host.wake(7'h55);
    @(posedge clk);
    wmode(GMF_INIT);
    chk("wake ocv", ocvN > k, 1'b1);
    wrr(OFS_CTRL, 16'h0011);
    ocv_done();
    wmode(GMF_NORMAL);
    wrr(OFS_CMD, CMD_CFGUPD);
    wmode(GMF_CFGUPD);
    flag("cfg", ST_CFGUPD, 1'b1);
    chk("gauge off", gaugeRun, 1'b0);
    wrr(OFS_CMD, CMD_SOFT_RESET);
    wmode(GMF_INIT);
    flag("cfg clr", ST_CFGUPD, 1'b0);
    flag("def clr", ST_DEFAULTS, 1'b0);
    k = ldN;
    wrr(OFS_CMD, CMD_RESET);
    @(posedge clk);
    flag("def set", ST_DEFAULTS, 1'b1);
    rdr(OFS_CTRL);
    chk("ctrl rl", v, CTRL_RESET);
    chk("dload", ldN > k, 1'b1);
    k = ocvN;
    wrr(OFS_CTRL, 16'h0012);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk("pin ocv", ocvN > k, 1'b1);
    ocv_done();
    wmode(GMF_NORMAL);
    pin <= 1'b1;
    wmode(GMF_INIT);
    test_done();
  end
endmodule

/* File: src/gmf_addr_watch.sv */
`timescale 1ns/1ps
module gmf_addr_watch #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset
  input wire logic sclPin, // Serial clock pin
  input wire logic sdaPin, // Serial data pin
  output logic hit // Pulse: our address seen
);
  logic [1:0] sclS_q, sdaS_q;
  logic sclOld_q, sdaOld_q, armed_q;
  logic [3:0] bits_q;
  logic [7:0] shift_q;

  // ==================================================
  // Two-stage synchronisers; stage 1 feeds only stage 2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclS_q <= 2'h3;
      sdaS_q <= 2'h3;
      sclOld_q <= 1'b1;
      sdaOld_q <= 1'b1;
    end else begin
      sclS_q <= {sclS_q[0], sclPin};
      sdaS_q <= {sdaS_q[0], sdaPin};
      sclOld_q <= sclS_q[1];
      sdaOld_q <= sdaS_q[1];
    end
  end

  // ==================================================
  // Address byte capture after each start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      bits_q <= 4'h0;
      shift_q <= 8'h0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (sclS_q[1] && sdaOld_q && !sdaS_q[1]) begin
        armed_q <= 1'b1;
        bits_q <= 4'h0;
      end else if (armed_q && sclS_q[1] && !sclOld_q) begin
        shift_q <= {shift_q[6:0], sdaS_q[1]};
        bits_q <= bits_q + 4'h1;
        if (bits_q == 4'h7) begin
          armed_q <= 1'b0;
          // Other targets' traffic never wakes us
          hit <= (shift_q[6:0] == DEV_ADDR);
        end
      end
    end
  end
endmodule

/* File: src/gmf_hold_timer.sv */
`timescale 1ns/1ps
module gmf_hold_timer #(
  parameter int unsigned CYCLES = 40_000_000
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Async reset
  input wire logic cond, // Condition to qualify
  output logic held // Condition stood long enough
);
  logic [31:0] cnt_q;

  // ==================================================
  // Persistence counter, restarts whenever the condition breaks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
    end else if (!cond) begin
      cnt_q <= 32'h0;
    end else if (cnt_q < CYCLES) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign held = cond && (cnt_q >= CYCLES);
endmodule

/* File: src/gmf_mode_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Gauge runs only after insertion and initialization
// - Temperature from host writes or sensor
// - Charge over-temperature flag with persistence, recovery
// - Discharge over-temperature flag with persistence, recovery
// - Two taper windows end charge, clear charging
// - Charge inhibit outside limits, cleared inside range
// - Power-on loads defaults, enters halted initialization
// - Power-on or reset command sets defaults flag
// - Insertion starts rest voltage, clears learned bits
// - Halted initialization wakes briefly for host commands
// - Config update command from initialization or normal suspends gauging, sets flag
// - Soft reset leaves update, clears both flags
// - Normal mode measures, updates data, picks modes
// - Sleep needs enable, low current, calibration first
// - Sleep stops oscillator, exits when condition breaks
// - Hibernate on request with rest voltage or undervoltage
// - Only our own bus address wakes hibernate
module gmf_mode_ctrl #(
  parameter int unsigned OT_CYC = gmf_pkg::OT_CYCLES,
  parameter int unsigned TAPER_CYC = gmf_pkg::TAPER_CYCLES,
  parameter int DESIGN_CAP_MAH = 1000,
  parameter logic signed [15:0] HIB_CURRENT_MA = 16'sh0008,
  parameter logic signed [15:0] HIB_VOLTAGE_MV = 16'sh09c4,
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [3:0] addr, // Register index
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  input wire logic battery_present_pin, // Presence pin, low = inserted
  input wire logic sclPin, // Serial clock pin
  input wire logic sdaPin, // Serial data pin
  input wire logic measValid, // Pulse: new measurement set
  input wire logic signed [15:0] sensorTemp, // On-chip temperature, 0.1 degC
  input wire logic signed [15:0] mean_current_reading, // mA, charge positive
  input wire logic signed [15:0] cellVoltage, // mV
  input wire logic [15:0] capStep, // Capacity change per sample, 0.01 mAh
  input wire logic ocvDone, // Pulse: rest voltage measured
  input wire logic calDone, // Pulse: offset calibration done
  input wire logic capLearnPulse, // Pulse: capacity learned
  input wire logic resLearnPulse, // Pulse: resistance learned
  output gmf_pkg::gmf_mode_e mode, // Operating mode
  output logic gaugeRun, // Gauging active
  output logic hfOscOn, // High-frequency oscillator on
  output logic ocvStart, // Pulse: start rest voltage
  output logic calStart, // Pulse: start offset calibration
  output logic dataUpdate, // Pulse: publish data set
  output logic cpuHalted, // Halted awaiting battery
  output logic defaultsLoad, // Pulse: copy defaults to RAM
  output logic remaining_from_full_on_termination, // Pulse on termination
  output logic signed [15:0] effTemp, // Temperature used by gauging
  output logic [15:0] status // Status flags
);
  import gmf_pkg::*;
  localparam logic signed [15:0] CHG_THR = 16'((DESIGN_CAP_MAH * 10) / 133);
  localparam logic signed [15:0] DSG_THR = 16'((DESIGN_CAP_MAH * 10) / 167);

  logic [15:0] ctrl_q, hostTemp_q;
  logic [1:0] pinS_q;
  logic cmdPresent_q, present_q;
  logic otc_q, otd_q, inh_q, chg_q, defaults_reloaded_flag_q, cfg_q, capL_q, resL_q, rest_voltage_captured_flag_q;
  logic initBusy_q, termLock_q, wake_q;
  gmf_mode_e mode_q, mode_d;
  logic [31:0] winCnt_q;
  logic [15:0] capAcc_q;
  logic winGood_q;
  logic passOne_q;
  logic otcHeld, otdHeld, busHit;
  logic isCmd, cmdInsert, cmdRemove, cmdCfg, cmdSoft, cmdReset;
  logic present, insertEv, removeEv, halted, sleepOk, hibOk, winEnd, winPass;

  function automatic logic signed [15:0] absval(input logic signed [15:0] v);
    absval = v[15] ? -v : v;
  endfunction

  // ==================================================
  // Helpers
  gmf_hold_timer #(.CYCLES(OT_CYC)) u_otcHold (
    .clk(clk),
    .rst_b(rst_b),
    .cond(chg_q && effTemp >= OT_CHG_SET),
    .held(otcHeld)
  );

  gmf_hold_timer #(.CYCLES(OT_CYC)) u_otdHold (
    .clk(clk),
    .rst_b(rst_b),
    .cond(!chg_q && effTemp >= OT_DSG_SET),
    .held(otdHeld)
  );

  gmf_addr_watch #(.DEV_ADDR(DEV_ADDR)) u_watch (
    .clk(clk),
    .rst_b(rst_b),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .hit(busHit)
  );

  // ==================================================
  // Command decode
  assign isCmd = wr && (addr == OFS_CMD);
  assign cmdInsert = isCmd && (wdata == CMD_INSERT);
  assign cmdRemove = isCmd && (wdata == CMD_REMOVE);
  assign cmdCfg = isCmd && (wdata == CMD_CFGUPD);
  assign cmdSoft = isCmd && (wdata == CMD_SOFT_RESET);
  assign cmdReset = isCmd && (wdata == CMD_RESET);

  // ==================================================
  // Register file
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      hostTemp_q <= TEMP_DEFAULT;
    end else if (cmdReset || mode_q == GMF_POR) begin
      ctrl_q <= CTRL_RESET;
      hostTemp_q <= TEMP_DEFAULT;
    end else if (wr && addr == OFS_CTRL) begin
      ctrl_q <= {11'h0, wdata[4:0]};
    end else if (wr && addr == OFS_TEMP) begin
      hostTemp_q <= wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0;
    end else if (!rd) begin
      rdata <= 16'h0;
    end else begin
      case (addr)
        OFS_CTRL: rdata <= ctrl_q;
        OFS_TEMP: rdata <= effTemp;
        OFS_STATUS: rdata <= status;
        OFS_MODE: rdata <= {13'h0, mode_q};
        default: rdata <= 16'h0;
      endcase
    end
  end

  // ==================================================
  // Battery detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS_q <= 2'h3;
      cmdPresent_q <= 1'b0;
      present_q <= 1'b0;
    end else begin
      pinS_q <= {pinS_q[0], battery_present_pin};
      present_q <= present;
      if (cmdInsert) begin
        cmdPresent_q <= 1'b1;
      end else if (cmdRemove || cmdReset) begin
        cmdPresent_q <= 1'b0;
      end
    end
  end

  // Pin low means a pack pulls it down against the pull-up
  assign present = ctrl_q[CTL_PIN_DET_EN] ? !pinS_q[1] : cmdPresent_q;
  assign insertEv = present && !present_q;
  assign removeEv = !present && present_q;
  assign halted = (mode_q == GMF_INIT) && !present;

  // ==================================================
  // Temperature source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      effTemp <= TEMP_DEFAULT;
    end else begin
      effTemp <= ctrl_q[CTL_HOST_TEMPERATURE_WRITE_ENABLE_EN] ? hostTemp_q : sensorTemp;
    end
  end

  // ==================================================
  // Temperature flags; set wins over recovery in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otc_q <= 1'b0;
      otd_q <= 1'b0;
      inh_q <= 1'b0;
    end else begin
      if (otcHeld && mean_current_reading > CHG_THR) begin
        otc_q <= 1'b1;
      end else if (effTemp <= OT_CHG_REC) begin
        otc_q <= 1'b0;
      end
      if (otdHeld && mean_current_reading <= -DSG_THR) begin
        otd_q <= 1'b1;
      end else if (effTemp <= OT_DSG_REC) begin
        otd_q <= 1'b0;
      end
      if (effTemp < INH_LOW || effTemp > INH_HIGH) begin
        inh_q <= 1'b1;
      end else if (effTemp >= CHG_TEMP_LOW && effTemp <= CHG_TEMP_HIGH) begin
        inh_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // Charge termination over taper windows
  assign winEnd = (winCnt_q == TAPER_CYC - 1);
  assign winPass = winGood_q && (capAcc_q > TAPER_CAP_MIN);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      winCnt_q <= 32'h0;
      capAcc_q <= 16'h0;
      winGood_q <= 1'b1;
      passOne_q <= 1'b0;
    end else if (!chg_q || winEnd) begin
      winCnt_q <= 32'h0;
      capAcc_q <= 16'h0;
      winGood_q <= 1'b1;
      passOne_q <= chg_q && winPass && !passOne_q;
    end else begin
      winCnt_q <= winCnt_q + 32'h1;
      if (measValid) begin
        capAcc_q <= (capAcc_q > 16'hffff - capStep) ? 16'hffff : capAcc_q + capStep;
        if (mean_current_reading >= TAPER_MA
            || cellVoltage <= CHG_VOLT_MV - TAPER_MARGIN_MV) begin
          winGood_q <= 1'b0;
        end
      end
    end
  end

  // Charging flag; the lock keeps it down until current stops flowing in
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_q <= 1'b0;
      termLock_q <= 1'b0;
      remaining_from_full_on_termination <= 1'b0;
    end else begin
      remaining_from_full_on_termination <= 1'b0;
      if (chg_q && winEnd && winPass && passOne_q) begin
        chg_q <= 1'b0;
        termLock_q <= 1'b1;
        remaining_from_full_on_termination <= ctrl_q[CTL_RM_FULL_EN];
      end else if (mean_current_reading <= 16'sh0000) begin
        chg_q <= 1'b0;
        termLock_q <= 1'b0;
      end else if (mean_current_reading > CHG_THR && !termLock_q) begin
        chg_q <= 1'b1;
      end
    end
  end

  // ==================================================
  // Mode sequencing
  assign sleepOk = ctrl_q[CTL_SLEEP_EN] && (mean_current_reading < SLEEP_MA);
  assign hibOk = ctrl_q[CTL_HIB_REQ] && ((rest_voltage_captured_flag_q
    && absval(mean_current_reading) < HIB_CURRENT_MA)
    || cellVoltage < HIB_VOLTAGE_MV);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      GMF_POR: mode_d = GMF_INIT;
      GMF_INIT: begin
        if (cmdCfg) begin
          mode_d = GMF_CFGUPD;
        end else if (present && !initBusy_q && !insertEv && rest_voltage_captured_flag_q) begin
          mode_d = GMF_NORMAL;
        end
      end
      GMF_NORMAL: begin
        if (cmdCfg) begin
          mode_d = GMF_CFGUPD;
        end else if (!present) begin
          mode_d = GMF_INIT;
        end else if (hibOk) begin
          mode_d = GMF_HIB;
        end else if (sleepOk) begin
          mode_d = GMF_CAL;
        end
      end
      GMF_CAL: mode_d = !sleepOk ? GMF_NORMAL : (calDone ? GMF_SLEEP : GMF_CAL);
      GMF_SLEEP: begin
        if (!sleepOk || !present || cmdCfg || hibOk) begin
          mode_d = GMF_NORMAL;
        end
      end
      GMF_CFGUPD: mode_d = cmdSoft ? GMF_INIT : GMF_CFGUPD;
      GMF_HIB: mode_d = busHit ? GMF_INIT : GMF_HIB;
      default: mode_d = GMF_POR;
    endcase
    if (cmdReset) begin
      mode_d = GMF_POR;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= GMF_POR;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==================================================
  // Initialization activity and status bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      defaults_reloaded_flag_q <= 1'b1;
      cfg_q <= 1'b0;
      capL_q <= 1'b0;
      resL_q <= 1'b0;
      rest_voltage_captured_flag_q <= 1'b0;
      initBusy_q <= 1'b0;
      ocvStart <= 1'b0;
    end else begin
      ocvStart <= 1'b0;
      if (mode_q == GMF_POR) begin
        defaults_reloaded_flag_q <= 1'b1;
      end else if (cmdSoft && mode_q == GMF_CFGUPD) begin
        defaults_reloaded_flag_q <= 1'b0;
      end
      if (mode_d == GMF_CFGUPD && mode_q != GMF_CFGUPD) begin
        cfg_q <= 1'b1;
      end else if (cmdSoft || mode_q == GMF_POR) begin
        cfg_q <= 1'b0;
      end
      // Learning is restarted on every new pack; the learn pulse wins
      if (capLearnPulse) begin
        capL_q <= 1'b1;
      end else if (insertEv) begin
        capL_q <= 1'b0;
      end
      if (resLearnPulse) begin
        resL_q <= 1'b1;
      end else if (insertEv) begin
        resL_q <= 1'b0;
      end
      if (ocvDone) begin
        rest_voltage_captured_flag_q <= 1'b1;
        initBusy_q <= 1'b0;
      end else if (mode_q != GMF_HIB && mode_d == GMF_HIB) begin
        rest_voltage_captured_flag_q <= 1'b0;
      end else if (insertEv || (mode_q == GMF_HIB && busHit)) begin
        rest_voltage_captured_flag_q <= 1'b0;
        initBusy_q <= 1'b1;
        ocvStart <= 1'b1;
      end else if (removeEv) begin
        initBusy_q <= 1'b0;
      end
    end
  end

  // ==================================================
  // Mode outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= GMF_POR;
      gaugeRun <= 1'b0;
      hfOscOn <= 1'b1;
      calStart <= 1'b0;
      dataUpdate <= 1'b0;
      cpuHalted <= 1'b0;
      defaultsLoad <= 1'b1;
      wake_q <= 1'b0;
      status <= 16'h0;
    end else begin
      mode <= mode_d;
      gaugeRun <= mode_d == GMF_NORMAL || mode_d == GMF_CAL
                  || mode_d == GMF_SLEEP;
      hfOscOn <= mode_d != GMF_SLEEP && mode_d != GMF_HIB;
      calStart <= mode_q == GMF_NORMAL && mode_d == GMF_CAL;
      // Sleep still measures periodically, at the measurement pace
      dataUpdate <= measValid && (mode_q == GMF_NORMAL || mode_q == GMF_SLEEP);
      defaultsLoad <= mode_d == GMF_POR;
      // Two awake cycles for each one-cycle host access while halted
      wake_q <= halted && (wr || rd);
      cpuHalted <= (mode_d == GMF_INIT) && !present && !(wr || rd) && !wake_q;
      status <= {6'h0, present, rest_voltage_captured_flag_q, resL_q, capL_q, cfg_q, defaults_reloaded_flag_q,
                 chg_q, inh_q, otd_q, otc_q};
    end
  end
endmodule

/* File: src/gmf_pkg.sv */
package gmf_pkg;
  // ==================================================
  // Clock and times
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OT_TIME_S = 2;
  localparam int unsigned TAPER_WINDOW_S = 40;
  localparam int unsigned OT_CYCLES = OT_TIME_S * CLK_HZ;
  localparam int unsigned TAPER_CYCLES = TAPER_WINDOW_S * CLK_HZ;
  // ==================================================
  // Register offsets (word index on addr)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h1;
  localparam logic [3:0] OFS_TEMP = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_MODE = 4'h4;
  // Control bits
  localparam int CTL_HOST_TEMPERATURE_WRITE_ENABLE_EN = 0;
  localparam int CTL_PIN_DET_EN = 1;
  localparam int CTL_SLEEP_EN = 2;
  localparam int CTL_HIB_REQ = 3;
  localparam int CTL_RM_FULL_EN = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0014;
  // Status bits
  localparam int ST_OTC = 0;
  localparam int ST_OTD = 1;
  localparam int ST_CHARGE_INHIBIT_FLAG = 2;
  localparam int ST_CHG = 3;
  localparam int ST_DEFAULTS = 4;
  localparam int ST_CFGUPD = 5;
  localparam int ST_CAP_LEARNED = 6;
  localparam int ST_RES_LEARNED = 7;
  localparam int ST_OCV_TAKEN = 8;
  localparam int ST_BATTERY_DETECTED_BIT = 9;
  // Subcommand codes
  localparam logic [15:0] CMD_INSERT = 16'h0001;
  localparam logic [15:0] CMD_REMOVE = 16'h0002;
  localparam logic [15:0] CMD_CFGUPD = 16'h0003;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h0004;
  localparam logic [15:0] CMD_RESET = 16'h0005;
  // Temperatures in 0.1 degC, currents in mA, voltage in mV
  localparam logic signed [15:0] TEMP_DEFAULT = 16'sh00fa;
  localparam logic signed [15:0] OT_CHG_SET = 16'sh0226;
  localparam logic signed [15:0] OT_CHG_REC = 16'sh01f4;
  localparam logic signed [15:0] OT_DSG_SET = 16'sh0258;
  localparam logic signed [15:0] OT_DSG_REC = 16'sh0226;
  localparam logic signed [15:0] INH_LOW = 16'sh0000;
  localparam logic signed [15:0] INH_HIGH = 16'sh01c2;
  localparam logic signed [15:0] CHG_TEMP_LOW = 16'sh0032;
  localparam logic signed [15:0] CHG_TEMP_HIGH = 16'sh0190;
  localparam logic signed [15:0] TAPER_MA = 16'sh0064;
  localparam logic signed [15:0] CHG_VOLT_MV = 16'sh1068;
  localparam logic signed [15:0] TAPER_MARGIN_MV = 16'sh0064;
  localparam logic [15:0] TAPER_CAP_MIN = 16'h0019;
  localparam logic signed [15:0] SLEEP_MA = 16'sh000a;
  // ==================================================
  // Operating modes
  typedef enum logic [2:0] {
    GMF_POR = 3'b000,
    GMF_INIT = 3'b001,
    GMF_NORMAL = 3'b010,
    GMF_CFGUPD = 3'b011,
    GMF_CAL = 3'b100,
    GMF_SLEEP = 3'b101,
    GMF_HIB = 3'b110
  } gmf_mode_e;
endpackage
